// ### logic/trap_xor_pkg.sv
/*
 * constants, field positions and operation kinds for the trap compare / xor execute block.
 * assumes a 32-bit instruction word and a 64-bit general register file.
 */
// Functional notes
// - opcode 000001 with second source field 01010 is trap_lt_signed_imm
// - trap_lt_signed_imm traps when register is signed-below the extended immediate
// - immediate sign-extends by 16 copies of bit 15, or 48 in 64-bit mode
// - opcode 000001 with second source field 01011 is trap_lt_unsigned_imm
// - trap_lt_unsigned_imm sign-extends, then compares unsigned; traps when register smaller
// - trap_lt_unsigned_reg under opcode 000000 traps when first source unsigned-below second
// - register trap formats ignore the ten-bit code field in bits 15..6
// - trap_not_equal_reg traps whenever the two source values differ; only the low words count in 32-bit mode
// - opcode 000001 with second source field 01110 is trap_not_equal_imm
// - trap_not_equal_imm traps when register differs from the extended immediate
// - opcode 000000, function 100110, bits 10..6 zero decodes as register xor
// - xor writes bitwise xor of both sources to destination, no exception
package trap_xor_pkg;
   localparam int XLEN     = 64;
   localparam int WORD     = 32;
   localparam int EXT32    = 16;
   localparam int EXT64    = 48;
   localparam int OPC_MSB  = 31;
   localparam int OPC_LSB  = 26;
   localparam int RS_MSB   = 25;
   localparam int RS_LSB   = 21;
   localparam int RT_MSB   = 20;
   localparam int RT_LSB   = 16;
   localparam int RD_MSB   = 15;
   localparam int RD_LSB   = 11;
   localparam int SH_MSB   = 10;
   localparam int SH_LSB   = 6;
   localparam int FN_MSB   = 5;
   localparam int FN_LSB   = 0;
   localparam int IMM_MSB  = 15;
   localparam int IMM_LSB  = 0;

   localparam logic [5:0] OPC_REGISTER_GROUP = 6'h00;
   localparam logic [5:0] OPC_GROUP_A        = 6'h01;
   localparam logic [5:0] FN_XOR             = 6'h26;
   localparam logic [5:0] FN_TRAP_LTU        = 6'h33;
   localparam logic [5:0] FN_TRAP_NE         = 6'h36;
   localparam logic [4:0] RT_TRAP_LTI        = 5'h0a;
   localparam logic [4:0] RT_TRAP_LTIU       = 5'h0b;
   localparam logic [4:0] RT_TRAP_NEI        = 5'h0e;
   localparam logic [4:0] SHIFT_ZERO         = 5'h00;
   localparam logic [4:0] INDEX_ZERO         = 5'h00;
   localparam logic [63:0] DATA_ZERO         = 64'h0;

   typedef enum logic [6:0] {
      OP_NONE = 7'b0000001,
      OP_LTSI = 7'b0000010,
      OP_LTUI = 7'b0000100,
      OP_LTUR = 7'b0001000,
      OP_NER  = 7'b0010000,
      OP_NEI  = 7'b0100000,
      OP_XOR  = 7'b1000000
   } op_e;
endpackage : trap_xor_pkg

// ### logic/compare_if.sv
/*
 * carrier between the execute top and its comparator.
 * assumes both ends sit on the same clock; the path is combinational.
 */
`timescale 1ns/1ps
interface compare_if;
   logic [63:0] lhs;
   logic [63:0] rhs;
   logic        wide;
   logic        ltSigned;
   logic        ltUnsigned;
   logic        notEqual;
   modport requester (output lhs, output rhs, output wide,
                      input ltSigned, input ltUnsigned, input notEqual);
   modport comparator (input lhs, input rhs, input wide,
                       output ltSigned, output ltUnsigned, output notEqual);
endinterface : compare_if

// ### logic/operand_compare.sv
/*
 * width-aware comparator: signed less, unsigned less and inequality.
 * assumes operands arrive already extended; in 32-bit mode only the low word counts.
 */
`timescale 1ns/1ps
module operand_compare (
   compare_if.comparator cmp
);
   logic [31:0] lhsWord;
   logic [31:0] rhsWord;

   assign lhsWord = cmp.lhs[trap_xor_pkg::WORD-1:0];
   assign rhsWord = cmp.rhs[trap_xor_pkg::WORD-1:0];

   always_comb begin
      if (cmp.wide) begin
         cmp.ltSigned   = $signed(cmp.lhs) < $signed(cmp.rhs);
         cmp.ltUnsigned = cmp.lhs < cmp.rhs;
         cmp.notEqual   = cmp.lhs != cmp.rhs;
      end else begin
         cmp.ltSigned   = $signed(lhsWord) < $signed(rhsWord);
         cmp.ltUnsigned = lhsWord < rhsWord;
         cmp.notEqual   = lhsWord != rhsWord;
      end
   end
endmodule : operand_compare

// ### logic/trap_compare_xor_exec.sv
/*
 * execute stage for the conditional traps and register xor.
 * assumes operands are read from the general register file by the pipeline and
 * presented with the instruction in the same cycle; results appear one cycle later.
 */
`timescale 1ns/1ps
module trap_compare_xor_exec (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        instrValid,
   input  wire logic [31:0] instrWord,
   input  wire logic        mode64,
   input  wire logic [63:0] firstSourceValue,
   input  wire logic [63:0] secondSourceValue,
   output logic             trapRequest,
   output logic             writeEnable,
   output logic [4:0]       writeIndex,
   output logic [63:0]      writeData,
   output logic             instrDone,
   output logic             notHandled
);
   compare_if cmp ();

   logic [5:0]        opcode;
   logic [4:0]        secondField;
   logic [4:0]        destField;
   logic [4:0]        shiftField;
   logic [5:0]        funcField;
   logic [15:0]       immField;
   logic [31:0]       immExt32;
   logic [63:0]       immExt;
   trap_xor_pkg::op_e op;
   logic              useImm;
   logic              trap_d;
   logic              writeEn_d;
   logic [4:0]        writeIndex_d;
   logic [63:0]       writeData_d;
   logic              done_d;
   logic              notHandled_d;
   logic              trap_q;
   logic              writeEn_q;
   logic [4:0]        writeIndex_q;
   logic [63:0]       writeData_q;
   logic              done_q;
   logic              notHandled_q;

   assign opcode      = instrWord[trap_xor_pkg::OPC_MSB:trap_xor_pkg::OPC_LSB];
   assign secondField = instrWord[trap_xor_pkg::RT_MSB:trap_xor_pkg::RT_LSB];
   assign destField   = instrWord[trap_xor_pkg::RD_MSB:trap_xor_pkg::RD_LSB];
   assign shiftField  = instrWord[trap_xor_pkg::SH_MSB:trap_xor_pkg::SH_LSB];
   assign funcField   = instrWord[trap_xor_pkg::FN_MSB:trap_xor_pkg::FN_LSB];
   assign immField    = instrWord[trap_xor_pkg::IMM_MSB:trap_xor_pkg::IMM_LSB];

   assign immExt32 = {{trap_xor_pkg::EXT32{immField[trap_xor_pkg::IMM_MSB]}}, immField};
   assign immExt   = mode64 ? {{trap_xor_pkg::EXT64{immField[trap_xor_pkg::IMM_MSB]}}, immField}
                            : {{trap_xor_pkg::WORD{immExt32[trap_xor_pkg::WORD-1]}}, immExt32};

   always_comb begin
      op = trap_xor_pkg::OP_NONE;
      if (opcode == trap_xor_pkg::OPC_GROUP_A) begin
         if (secondField == trap_xor_pkg::RT_TRAP_LTI) begin
            op = trap_xor_pkg::OP_LTSI;
         end else if (secondField == trap_xor_pkg::RT_TRAP_LTIU) begin
            op = trap_xor_pkg::OP_LTUI;
         end else if (secondField == trap_xor_pkg::RT_TRAP_NEI) begin
            op = trap_xor_pkg::OP_NEI;
         end
      end else if (opcode == trap_xor_pkg::OPC_REGISTER_GROUP) begin
         if (funcField == trap_xor_pkg::FN_TRAP_LTU) begin
            op = trap_xor_pkg::OP_LTUR;
         end else if (funcField == trap_xor_pkg::FN_TRAP_NE) begin
            op = trap_xor_pkg::OP_NER;
         end else if (funcField == trap_xor_pkg::FN_XOR &&
                      shiftField == trap_xor_pkg::SHIFT_ZERO) begin
            op = trap_xor_pkg::OP_XOR;
         end
      end
   end

   assign useImm   = (op == trap_xor_pkg::OP_LTSI) || (op == trap_xor_pkg::OP_LTUI) ||
                     (op == trap_xor_pkg::OP_NEI);
   assign cmp.lhs  = firstSourceValue;
   assign cmp.rhs  = useImm ? immExt : secondSourceValue;
   assign cmp.wide = mode64;

   operand_compare compareUnit (
      .cmp (cmp)
   );

   always_comb begin
      trap_d       = 1'b0;
      writeEn_d    = 1'b0;
      writeIndex_d = trap_xor_pkg::INDEX_ZERO;
      writeData_d  = trap_xor_pkg::DATA_ZERO;
      done_d       = instrValid;
      // refused words complete with no trap and no write
      notHandled_d = instrValid && (op == trap_xor_pkg::OP_NONE);
      if (instrValid) begin
         case (op)
            trap_xor_pkg::OP_LTSI: trap_d = cmp.ltSigned;
            trap_xor_pkg::OP_LTUI: trap_d = cmp.ltUnsigned;
            trap_xor_pkg::OP_LTUR: trap_d = cmp.ltUnsigned;
            trap_xor_pkg::OP_NER:  trap_d = cmp.notEqual;
            trap_xor_pkg::OP_NEI:  trap_d = cmp.notEqual;
            trap_xor_pkg::OP_XOR: begin
               writeEn_d    = 1'b1;
               writeIndex_d = destField;
               writeData_d  = firstSourceValue ^ secondSourceValue;
            end
            default: trap_d = 1'b0;
         endcase
      end
   end

   // one-cycle trap pulse, never with a register write
   always_ff @(posedge clk) begin
      if (rst) begin
         trap_q       <= 1'b0;
         writeEn_q    <= 1'b0;
         writeIndex_q <= trap_xor_pkg::INDEX_ZERO;
         writeData_q  <= trap_xor_pkg::DATA_ZERO;
         done_q       <= 1'b0;
         notHandled_q <= 1'b0;
      end else begin
         trap_q       <= trap_d;
         writeEn_q    <= writeEn_d;
         writeIndex_q <= writeIndex_d;
         writeData_q  <= writeData_d;
         done_q       <= done_d;
         notHandled_q <= notHandled_d;
      end
   end

   assign trapRequest = trap_q;
   assign writeEnable = writeEn_q;
   assign writeIndex  = writeIndex_q;
   assign writeData   = writeData_q;
   assign instrDone   = done_q;
   assign notHandled  = notHandled_q;

   // checks, recomputed from the raw instruction word
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic groupA;
   logic regGroup;
   assign groupA   = instrValid && opcode == trap_xor_pkg::OPC_GROUP_A;
   assign regGroup = instrValid && opcode == trap_xor_pkg::OPC_REGISTER_GROUP;

   // raw comparisons kept as plain signals so the checks sample a signal, not an expression
   logic        ltuRaw;
   logic        neRaw;
   logic [63:0] immWide;
   assign ltuRaw  = firstSourceValue < secondSourceValue;
   assign neRaw   = firstSourceValue != secondSourceValue;
   assign immWide = {{trap_xor_pkg::EXT64{immField[trap_xor_pkg::IMM_MSB]}}, immField};

   sequence ltsiTrue;
      groupA && secondField == trap_xor_pkg::RT_TRAP_LTI && mode64 &&
      $signed(firstSourceValue) < $signed({{trap_xor_pkg::EXT64{immField[15]}}, immField});
   endsequence
   sequence xorIssue;
      regGroup && funcField == trap_xor_pkg::FN_XOR && shiftField == trap_xor_pkg::SHIFT_ZERO;
   endsequence
   sequence xorResult;
      writeEnable && !trapRequest && writeIndex == $past(destField) &&
      writeData == ($past(firstSourceValue) ^ $past(secondSourceValue));
   endsequence

   signed_lt_trap_a: assert property (ltsiTrue |=> trapRequest)
      else $error("signed immediate trap missed");
   signed_ge_quiet_a: assert property (groupA && secondField == trap_xor_pkg::RT_TRAP_LTI &&
         !mode64 && $signed(firstSourceValue[31:0]) >= $signed(immExt32) |=> !trapRequest)
      else $error("signed immediate trap raised wrongly");
   unsigned_imm_trap_a: assert property (groupA && secondField == trap_xor_pkg::RT_TRAP_LTIU &&
         mode64 && firstSourceValue < {{48{immField[15]}}, immField} |=> trapRequest)
      else $error("unsigned immediate trap missed");
   unsigned_reg_trap_a: assert property (regGroup && funcField == trap_xor_pkg::FN_TRAP_LTU &&
         mode64 |=> trapRequest == $past(ltuRaw))
      else $error("unsigned register trap wrong");
   reg_ne_trap_a: assert property (regGroup && funcField == trap_xor_pkg::FN_TRAP_NE && mode64
         |=> trapRequest == $past(neRaw))
      else $error("register inequality trap wrong");
   imm_ne_trap_a: assert property (groupA && secondField == trap_xor_pkg::RT_TRAP_NEI &&
         !mode64 && firstSourceValue[31:0] != immExt32 |=> trapRequest)
      else $error("immediate inequality trap missed");
   xor_write_a: assert property (xorIssue |=> xorResult)
      else $error("xor result not written");
   xor_shift_reject_a: assert property (regGroup && funcField == trap_xor_pkg::FN_XOR &&
         shiftField != trap_xor_pkg::SHIFT_ZERO |=> !writeEnable && notHandled)
      else $error("xor with nonzero shift field accepted");
   trap_no_write_a: assert property (trapRequest |-> !writeEnable ##1 !trapRequest ||
         $past(instrValid))
      else $error("trap pulse with write or stale");
   imm_ne_quiet_a: assert property (groupA && secondField == trap_xor_pkg::RT_TRAP_NEI &&
         mode64 && firstSourceValue == immWide |=> !trapRequest)
      else $error("immediate inequality trap raised wrongly");
   unsigned_imm_quiet_a: assert property (groupA && secondField == trap_xor_pkg::RT_TRAP_LTIU &&
         mode64 && firstSourceValue >= immWide |=> !trapRequest)
      else $error("unsigned immediate trap raised wrongly");
   done_pulse_a: assert property (instrValid |=> instrDone)
      else $error("instruction not completed");
   done_idle_a: assert property (!instrValid |=>
         !instrDone && !trapRequest && !writeEnable)
      else $error("output pulse without instruction");
   foreign_op_a: assert property (instrValid && opcode != trap_xor_pkg::OPC_GROUP_A &&
         opcode != trap_xor_pkg::OPC_REGISTER_GROUP |=> notHandled && !trapRequest)
      else $error("foreign instruction not refused");
endmodule : trap_compare_xor_exec

// ### bench/trap_compare_xor_exec_tb.sv
/*
 * self-checking bench for the trap compare / xor execute block.
 * assumes the block answers one cycle after each issued instruction, as the hand-over states.
 */
`timescale 1ns/1ps
module trap_compare_xor_exec_tb;
   logic        clk;
   logic        rst;
   logic        instrValid;
   logic [31:0] instrWord;
   logic        mode64;
   logic [63:0] firstSourceValue;
   logic [63:0] secondSourceValue;
   logic        trapRequest;
   logic        writeEnable;
   logic [4:0]  writeIndex;
   logic [63:0] writeData;
   logic        instrDone;
   logic        notHandled;
   int          n_fail;
   int          checks_done;

   trap_compare_xor_exec i_trap_compare_xor_exec (
      .clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord), .mode64(mode64),
      .firstSourceValue(firstSourceValue), .secondSourceValue(secondSourceValue),
      .trapRequest(trapRequest), .writeEnable(writeEnable), .writeIndex(writeIndex),
      .writeData(writeData), .instrDone(instrDone), .notHandled(notHandled));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] immWord(input logic [4:0] sel, input logic [15:0] imm);
      return {6'h01, 5'h03, sel, imm};
   endfunction : immWord

   function automatic logic [31:0] regWord(input logic [9:0] mid, input logic [5:0] fn);
      return {6'h00, 5'h03, 5'h04, mid, fn};
   endfunction : regWord

   task automatic drive(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                        input logic m);
      @(posedge clk);
      instrValid        <= 1'b1;
      instrWord         <= w;
      firstSourceValue  <= a;
      secondSourceValue <= b;
      mode64            <= m;
   endtask : drive

   // outputs are registered, so look just after the answering edge
   task automatic expect_out(input logic t, input logic we, input logic [4:0] idx,
                             input logic [63:0] d, input logic nh, input logic done);
      #1;
      check(trapRequest, t, "trap request");
      check(writeEnable, we, "write enable");
      check(writeIndex, idx, "write index");
      check(writeData, d, "write data");
      check(notHandled, nh, "not handled");
      check(instrDone, done, "done");
   endtask : expect_out

   task automatic run(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                      input logic m, input logic t, input logic we, input logic [4:0] idx,
                      input logic [63:0] d, input logic nh);
      drive(w, a, b, m);
      @(posedge clk);
      instrValid <= 1'b0;
      expect_out(t, we, idx, d, nh, 1'b1);
   endtask : run

   task automatic trapCase(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b,
                           input logic m, input logic t);
      run(w, a, b, m, t, 1'b0, 5'h00, 64'h0, 1'b0);
   endtask : trapCase

   task automatic test_lt_signed();
      trapCase(immWord(5'h0a, 16'hffff), 64'hfffffffffffffffe, 64'h7, 1'b1, 1'b1);
      trapCase(immWord(5'h0a, 16'hffff), 64'hffffffffffffffff, 64'h7, 1'b1, 1'b0);
      trapCase(immWord(5'h0a, 16'h8000), 64'h5, 64'h7, 1'b1, 1'b0);
      trapCase(immWord(5'h0a, 16'h0000), 64'h00000001fffffffe, 64'h7, 1'b0, 1'b1);
      trapCase(immWord(5'h0a, 16'h0000), 64'h00000001fffffffe, 64'h7, 1'b1, 1'b0);
      trapCase(immWord(5'h0a, 16'h8000), 64'hffffffff00000000, 64'h7, 1'b0, 1'b0);
      $display("test lt_signed done");
   endtask : test_lt_signed

   // a zero-extended immediate would not trap on the three immediate cases here
   task automatic test_lt_unsigned();
      trapCase(immWord(5'h0b, 16'h8000), 64'h9000, 64'h0, 1'b1, 1'b1);
      trapCase(immWord(5'h0b, 16'hffff), 64'hffffffffffffffff, 64'h0, 1'b1, 1'b0);
      trapCase(immWord(5'h0b, 16'h8000), 64'hffffffffffff0000, 64'h0, 1'b0, 1'b1);
      trapCase(regWord(10'h3ff, 6'h33), 64'h1, 64'hffffffffffffffff, 1'b1, 1'b1);
      trapCase(regWord(10'h000, 6'h33), 64'h9, 64'h9, 1'b1, 1'b0);
      trapCase(regWord(10'h2aa, 6'h33), 64'ha, 64'h9, 1'b1, 1'b0);
      $display("test lt_unsigned done");
   endtask : test_lt_unsigned

   task automatic test_not_equal();
      trapCase(regWord(10'h155, 6'h36), 64'h8000000000000001, 64'h8000000000000001, 1'b1,
               1'b0);
      trapCase(regWord(10'h155, 6'h36), 64'h8000000000000001, 64'h1, 1'b1, 1'b1);
      trapCase(immWord(5'h0e, 16'h8000), 64'hffffffffffff8000, 64'h3, 1'b1, 1'b0);
      trapCase(immWord(5'h0e, 16'h8000), 64'h8000, 64'h3, 1'b1, 1'b1);
      trapCase(immWord(5'h0e, 16'h8000), 64'h12345678ffff8000, 64'h3, 1'b0, 1'b0);
      trapCase(immWord(5'h0e, 16'h8000), 64'h00000000ffff8001, 64'h3, 1'b0, 1'b1);
      $display("test not_equal done");
   endtask : test_not_equal

   task automatic test_xor();
      logic [63:0] a;
      logic [63:0] b;
      a = 64'hf0f0123456789abc;
      b = 64'h0ff0fedcba987654;
      run(regWord({5'h05, 5'h00}, 6'h26), a, b, 1'b1, 1'b0, 1'b1, 5'h05, a ^ b, 1'b0);
      run(regWord({5'h1f, 5'h00}, 6'h26), b, a, 1'b0, 1'b0, 1'b1, 5'h1f, a ^ b, 1'b0);
      run(regWord({5'h05, 5'h01}, 6'h26), a, b, 1'b1, 1'b0, 1'b0, 5'h00, 64'h0, 1'b1);
      run(regWord({5'h05, 5'h00}, 6'h27), a, b, 1'b1, 1'b0, 1'b0, 5'h00, 64'h0, 1'b1);
      run(regWord(10'h000, 6'h32), 64'h1, 64'h2, 1'b1, 1'b0, 1'b0, 5'h00, 64'h0, 1'b1);
      run(immWord(5'h0c, 16'h0001), 64'h1, a, 1'b1, 1'b0, 1'b0, 5'h00, 64'h0, 1'b1);
      run({6'h0e, 26'h0}, a, b, 1'b1, 1'b0, 1'b0, 5'h00, 64'h0, 1'b1);
      $display("test xor done");
   endtask : test_xor

   // issue every cycle: each answer must land one cycle after its own issue
   task automatic test_back_to_back();
      drive(immWord(5'h0b, 16'h8000), 64'h9000, 64'h0, 1'b1);
      drive(regWord({5'h1f, 5'h00}, 6'h26), 64'h3, 64'h5, 1'b0);
      expect_out(1'b1, 1'b0, 5'h00, 64'h0, 1'b0, 1'b1);
      @(posedge clk);
      instrValid <= 1'b0;
      expect_out(1'b0, 1'b1, 5'h1f, 64'h6, 1'b0, 1'b1);
      @(posedge clk);
      expect_out(1'b0, 1'b0, 5'h00, 64'h0, 1'b0, 1'b0);
      $display("test back_to_back done");
   endtask : test_back_to_back

   task automatic test_reset();
      drive(regWord({5'h02, 5'h00}, 6'h26), 64'h1, 64'h2, 1'b1);
      rst <= 1'b1;
      @(posedge clk);
      instrValid <= 1'b0;
      expect_out(1'b0, 1'b0, 5'h00, 64'h0, 1'b0, 1'b0);
      @(posedge clk);
      rst <= 1'b0;
      $display("test reset done");
   endtask : test_reset

   initial begin
      rst = 1'b1;
      instrValid = 1'b0;
      instrWord = 32'h0;
      mode64 = 1'b1;
      firstSourceValue = 64'h0;
      secondSourceValue = 64'h0;
      n_fail = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      expect_out(1'b0, 1'b0, 5'h00, 64'h0, 1'b0, 1'b0);
      test_lt_signed();
      test_lt_unsigned();
      test_not_equal();
      test_xor();
      test_back_to_back();
      test_reset();
      test_lt_signed();
      finish_test();
   end

   // roughly twenty-eight times the expected run length
   initial begin
      #50000;
      n_fail++;
      $display("ERROR at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule : trap_compare_xor_exec_tb
